// ==== pkg/pmf_defs.svh ====
// Constants of the output-voltage fault supervisor: command codes,
// reset values, field positions and timing counts.
// Assumes inclusion by bare name from any design file.
`ifndef PMF_DEFS_SVH
`define PMF_DEFS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define PMF_CODE_OV_WARN     8'h42
`define PMF_CODE_UV_WARN     8'h43
`define PMF_CODE_UV_FAULT    8'h44
`define PMF_CODE_UV_RESPONSE 8'h45
`define PMF_CODE_TIME_UNIT   8'hD2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMF_RST_OV_WARN     16'hFFFF
`define PMF_RST_UV_WARN     16'h0000
`define PMF_RST_UV_FAULT    16'h0000
`define PMF_RST_UV_RESPONSE 8'h80
`define PMF_RST_TIME_UNIT   16'h0001

// ----------------------------------------
// Response byte fields
// ----------------------------------------
`define PMF_MODE_MSB  7
`define PMF_MODE_LSB  6
`define PMF_RETRY_MSB 5
`define PMF_RETRY_LSB 3
`define PMF_DELAY_MSB 2
`define PMF_DELAY_LSB 0
`define PMF_RETRY_NONE 3'h0
`define PMF_RETRY_CONT 3'h7

// ----------------------------------------
// Delay field decode, in time units
// ----------------------------------------
`define PMF_DLY_C0 8'h01
`define PMF_DLY_C1 8'h02
`define PMF_DLY_C2 8'h04
`define PMF_DLY_C3 8'h10
`define PMF_DLY_C4 8'h01
`define PMF_DLY_C5 8'h20
`define PMF_DLY_C6 8'h40
`define PMF_DLY_C7 8'h80

// ----------------------------------------
// Timing: one time-unit step is 1 us
// ----------------------------------------
`define PMF_CLK_PERIOD_NS 20
`define PMF_UNIT_STEP_NS  1000
`define PMF_UNIT_STEP_CYCLES \
  ((`PMF_UNIT_STEP_NS + `PMF_CLK_PERIOD_NS - 1) / `PMF_CLK_PERIOD_NS)

`endif

// ==== pkg/pmf_pkg.sv ====
// Types of the output-voltage fault supervisor.
// Assumes the constants header is compiled alongside.
package pmf_pkg;

  // ----------------------------------------
  // Response modes
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    MODE_IGNORE        = 2'b00,
    MODE_DELAY_RETRY   = 2'b01,
    MODE_DISABLE_RETRY = 2'b10,
    MODE_DISABLE_WHILE = 2'b11
  } pmf_mode_t;

  // ----------------------------------------
  // Supervisor states
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ST_OFF   = 3'b000,
    ST_RUN   = 3'b001,
    ST_CONT  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_TRY   = 3'b100,
    ST_LATCH = 3'b101,
    ST_HOLD  = 3'b110
  } pmf_state_t;

endpackage

// ==== pkg/pmf_timer_if.sv ====
// Request and completion signals between supervisor and delay timer.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface pmf_timer_if;
  logic        start;
  logic [2:0]  code;
  logic [15:0] unit;
  logic        busy;
  logic        done;

  modport ctl (output start, code, unit, input busy, done);
  modport tmr (input start, code, unit, output busy, done);
endinterface

// ==== rtl/pmf_delay_timer.sv ====
// Delay timer: counts decoded delay field times the time-unit setting.
// Assumes a 1 us step derived from clk_sys; start reloads at any time.
`timescale 1ns/100ps
`include "pmf_defs.svh"
module pmf_delay_timer
  import pmf_pkg::*;
#(
  parameter int STEP_CYCLES = `PMF_UNIT_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Supervisor side
  pmf_timer_if.tmr  tif
);

  localparam int PRE_W = 8;

  // Refuse steps the prescaler cannot count
  if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << PRE_W))
  begin
    $error("pmf_delay_timer: STEP_CYCLES out of range");
  end

  // ----------------------------------------
  // Delay field decode
  // ----------------------------------------
  localparam logic [7:0] DLY_LUT [8] = '{`PMF_DLY_C0, `PMF_DLY_C1, `PMF_DLY_C2,
    `PMF_DLY_C3, `PMF_DLY_C4, `PMF_DLY_C5, `PMF_DLY_C6, `PMF_DLY_C7};

  logic [PRE_W-1:0] pre_reg;
  logic [15:0]      step_reg;
  logic [7:0]       left_reg;
  logic             busy_reg;

  wire logic [7:0]  dly_units = DLY_LUT[tif.code];
  wire logic [15:0] unit_eff  = (tif.unit == 16'h0000) ? 16'h0001 : tif.unit;
  wire logic        step_tick = busy_reg && (pre_reg == PRE_W'(STEP_CYCLES - 1));
  wire logic        unit_tick = step_tick && (step_reg == unit_eff - 16'h0001);
  wire logic        last_unit = unit_tick && (left_reg == 8'h01);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || tif.start)
    begin
      pre_reg  <= '0;
      step_reg <= '0;
    end
    else if (busy_reg)
    begin
      pre_reg  <= step_tick ? '0 : pre_reg + PRE_W'(1);
      step_reg <= unit_tick ? '0 : (step_tick ? step_reg + 16'h0001 : step_reg);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      left_reg <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      left_reg <= tif.start ? dly_units : (unit_tick ? left_reg - 8'h01 : left_reg);
      busy_reg <= tif.start || (busy_reg && !last_unit);
    end
  end

  assign tif.busy = busy_reg;
  // Done in the last counted cycle, so the next start is one delay later
  assign tif.done = last_unit;

endmodule

// ==== rtl/pmf_fault_supervisor.sv ====
// Output-voltage fault supervisor: limit registers, comparison and
// the programmed under-voltage fault response with retries.
// Assumes command writes and reads arrive already decoded from the
// management bus, and the measurement is synchronous to clk_sys.
//
// Behaviour
// - Retry codes 100, 101, 110 give 4, 5, 6 restart attempts, then the output stays off until cleared.
// - Retry code 111 retries without limit until commanded off, bias is lost or another fault shuts down.
// - Successive restart attempts start one delay interval apart, the delay field times the time unit.
// - The delay field decodes to 1, 2, 4, 16, 32, 64, 128 units for 0, 1, 2, 3, 5, 6, 7; 4 decodes to 1 unit.
// - The decoded delay is the keep-running time in delayed mode and the restart spacing in modes 01 and 10.
// - One delay time unit is taken from the time-unit register at code 0xD2.
// - A 16-bit unsigned over-voltage warning limit sits at code 0x42.
// - A 16-bit unsigned under-voltage warning limit sits at code 0x43.
// - A 16-bit unsigned under-voltage fault limit in output-voltage format sits at code 0x44.
// - The under-voltage fault response byte sits at code 0x45 and steers the reaction to that fault.
// - Mode 00 ignores, 01 runs for the delay then retries, 10 disables and retries, 11 disables while present.
// - Retry code 000 makes no attempt and holds the output off; 001 to 011 give one to three attempts.
`timescale 1ns/100ps
`include "pmf_defs.svh"
module pmf_fault_supervisor
  import pmf_pkg::*;
#(
  parameter int STEP_CYCLES = `PMF_UNIT_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Command register port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_code,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_hit,
  // On/off control and supply state
  input  wire logic        ctrl_pin,
  input  wire logic        op_on,
  input  wire logic        bias_ok,
  input  wire logic        other_fault_off,
  input  wire logic        fault_clear,
  // Measurement
  input  wire logic [15:0] vout_meas,
  // Output control and status
  output logic             vout_enable,
  output logic             ov_warn,
  output logic             uv_warn,
  output logic             uv_fault,
  output logic             fault_off,
  output logic             retry_active,
  output logic [2:0]       attempt_count
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ov_warn_lim_reg;
  logic [15:0] uv_warn_lim_reg;
  logic [15:0] uv_fault_lim_reg;
  logic [7:0]  uv_resp_reg;
  logic [15:0] time_unit_reg;

  wire logic hit_ov_warn  = reg_code == `PMF_CODE_OV_WARN;
  wire logic hit_uv_warn  = reg_code == `PMF_CODE_UV_WARN;
  wire logic hit_uv_fault = reg_code == `PMF_CODE_UV_FAULT;
  wire logic hit_uv_resp  = reg_code == `PMF_CODE_UV_RESPONSE;
  wire logic hit_unit     = reg_code == `PMF_CODE_TIME_UNIT;
  wire logic hit_any      = hit_ov_warn | hit_uv_warn | hit_uv_fault
                          | hit_uv_resp | hit_unit;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ov_warn_lim_reg  <= `PMF_RST_OV_WARN;
      uv_warn_lim_reg  <= `PMF_RST_UV_WARN;
      uv_fault_lim_reg <= `PMF_RST_UV_FAULT;
      uv_resp_reg      <= `PMF_RST_UV_RESPONSE;
      time_unit_reg    <= `PMF_RST_TIME_UNIT;
    end
    else if (reg_wr_en)
    begin
      if (hit_ov_warn)
        ov_warn_lim_reg <= reg_wdata;
      if (hit_uv_warn)
        uv_warn_lim_reg <= reg_wdata;
      if (hit_uv_fault)
        uv_fault_lim_reg <= reg_wdata;
      if (hit_uv_resp)
        uv_resp_reg <= reg_wdata[7:0];
      if (hit_unit)
        time_unit_reg <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [15:0] rd_mux =
      hit_ov_warn  ? ov_warn_lim_reg  :
      hit_uv_warn  ? uv_warn_lim_reg  :
      hit_uv_fault ? uv_fault_lim_reg :
      hit_uv_resp  ? {8'h00, uv_resp_reg} :
      hit_unit     ? time_unit_reg    : 16'h0000;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      reg_rdata <= 16'h0000;
      reg_hit   <= 1'b0;
    end
    else if (reg_rd_en)
    begin
      reg_rdata <= rd_mux;
      reg_hit   <= hit_any;
    end
  end

  // ----------------------------------------
  // Control pin synchroniser
  // ----------------------------------------
  logic ctrl_meta_reg;
  logic ctrl_sync_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_meta_reg <= 1'b0;
      ctrl_sync_reg <= 1'b0;
    end
    else
    begin
      ctrl_meta_reg <= ctrl_pin;
      ctrl_sync_reg <= ctrl_meta_reg;
    end
  end

  // ----------------------------------------
  // Comparators and delay timer
  // ----------------------------------------
  logic uv_fault_now;

  pmf_vout_compare u_compare
  (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .vout_meas    (vout_meas),
    .ov_warn_lim  (ov_warn_lim_reg),
    .uv_warn_lim  (uv_warn_lim_reg),
    .uv_fault_lim (uv_fault_lim_reg),
    .ov_warn      (ov_warn),
    .uv_warn      (uv_warn),
    .uv_fault     (uv_fault_now)
  );

  assign uv_fault = uv_fault_now;

  pmf_timer_if tif ();

  pmf_delay_timer #(.STEP_CYCLES (STEP_CYCLES)) u_timer
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tif     (tif.tmr)
  );

  // ----------------------------------------
  // Response decode
  // ----------------------------------------
  wire pmf_mode_t  resp_mode = pmf_mode_t'(uv_resp_reg[`PMF_MODE_MSB:`PMF_MODE_LSB]);
  wire logic [2:0] retry_lim = uv_resp_reg[`PMF_RETRY_MSB:`PMF_RETRY_LSB];
  wire logic       retry_cont = retry_lim == `PMF_RETRY_CONT;
  wire logic       no_retry   = retry_lim == `PMF_RETRY_NONE;

  // Any off command, lost bias or foreign shutdown ends every sequence
  wire logic run_cmd = ctrl_sync_reg && op_on && bias_ok && !other_fault_off;

  pmf_state_t state_reg;
  pmf_state_t state_next;
  logic [2:0] att_reg;
  logic [2:0] att_next;
  logic       tstart;

  wire logic [2:0] att_inc  = (att_reg == 3'h7) ? 3'h7 : att_reg + 3'h1;
  wire logic       try_more = retry_cont || (att_reg < retry_lim);

  assign tif.start = tstart;
  assign tif.code  = uv_resp_reg[`PMF_DELAY_MSB:`PMF_DELAY_LSB];
  assign tif.unit  = time_unit_reg;

  // ----------------------------------------
  // Fault response sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    att_next   = att_reg;
    tstart     = 1'b0;
    unique case (state_reg)
      ST_OFF:
        if (run_cmd)
        begin
          state_next = ST_RUN;
          att_next   = 3'h0;
        end
      ST_RUN:
        if (uv_fault_now)
        begin
          unique case (resp_mode)
            MODE_IGNORE: ;
            MODE_DELAY_RETRY:
            begin
              state_next = ST_CONT;
              tstart     = 1'b1;
            end
            MODE_DISABLE_RETRY:
            begin
              state_next = no_retry ? ST_LATCH : ST_WAIT;
              tstart     = !no_retry;
              att_next   = 3'h0;
            end
            MODE_DISABLE_WHILE:
              state_next = ST_HOLD;
          endcase
        end
      ST_CONT:
        if (!uv_fault_now)
          state_next = ST_RUN;
        else if (tif.done)
        begin
          state_next = no_retry ? ST_LATCH : ST_WAIT;
          tstart     = !no_retry;
          att_next   = 3'h0;
        end
      ST_WAIT:
        if (tif.done)
        begin
          state_next = ST_TRY;
          att_next   = att_inc;
          tstart     = 1'b1;
        end
      ST_TRY:
        if (tif.done)
        begin
          if (!uv_fault_now)
          begin
            state_next = ST_RUN;
            att_next   = 3'h0;
          end
          else if (try_more)
          begin
            att_next = att_inc;
            tstart   = 1'b1;
          end
          else
            state_next = ST_LATCH;
        end
      ST_LATCH:
        if (fault_clear)
        begin
          state_next = ST_RUN;
          att_next   = 3'h0;
        end
      ST_HOLD:
        if (!uv_fault_now)
          state_next = ST_RUN;
      default:
        state_next = ST_OFF;
    endcase
    if (!run_cmd)
    begin
      state_next = ST_OFF;
      att_next   = 3'h0;
      tstart     = 1'b0;
    end
  end

  wire logic en_next = (state_next == ST_RUN) || (state_next == ST_CONT)
                    || (state_next == ST_TRY);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg     <= ST_OFF;
      att_reg       <= 3'h0;
      vout_enable   <= 1'b0;
      fault_off     <= 1'b0;
      retry_active  <= 1'b0;
      attempt_count <= 3'h0;
    end
    else
    begin
      state_reg     <= state_next;
      att_reg       <= att_next;
      vout_enable   <= en_next;
      fault_off     <= state_next == ST_LATCH;
      retry_active  <= (state_next == ST_WAIT) || (state_next == ST_TRY);
      attempt_count <= att_next;
    end
  end

endmodule

// ==== rtl/pmf_vout_compare.sv ====
// Output voltage comparators against the programmed limits.
// Assumes the measurement is a synchronous word on clk_sys.
`timescale 1ns/100ps
module pmf_vout_compare
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Measurement and limits
  input  wire logic [15:0] vout_meas,
  input  wire logic [15:0] ov_warn_lim,
  input  wire logic [15:0] uv_warn_lim,
  input  wire logic [15:0] uv_fault_lim,
  // Flags
  output logic             ov_warn,
  output logic             uv_warn,
  output logic             uv_fault
);

  wire logic ov_warn_hit  = vout_meas > ov_warn_lim;
  wire logic uv_warn_hit  = vout_meas < uv_warn_lim;
  wire logic uv_fault_hit = vout_meas < uv_fault_lim;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ov_warn  <= 1'b0;
      uv_warn  <= 1'b0;
      uv_fault <= 1'b0;
    end
    else
    begin
      ov_warn  <= ov_warn_hit;
      uv_warn  <= uv_warn_hit;
      uv_fault <= uv_fault_hit;
    end
  end

endmodule

// ==== test/pmbus_fault_retry_limits_bench.sv ====
// Testbench: registers, comparators and fault responses of the supervisor.
// Assumes the host model and checker compiled alongside the design.
`timescale 1ns/100ps
`include "pmf_defs.svh"
module pmbus_fault_retry_limits_bench;
  // ----------------
  // Stimulus and model state
  // ----------------
  localparam int STEP = 2;
  localparam int UNITS [8] = '{1, 2, 4, 16, 1, 32, 64, 128};
  localparam logic [3:0] OFFS [4] = '{4'h6, 4'hA, 4'hC, 4'hF};
  localparam logic [15:0] V_OK = 16'h2000;
  localparam logic [15:0] V_LOW = 16'h0800;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        ctrl_pin = 1'b1;
  logic        op_on = 1'b0;
  logic        bias_ok = 1'b1;
  logic        other_fault_off = 1'b0;
  logic        fault_clear = 1'b0;
  logic [15:0] vout_meas = V_OK;
  logic        reg_wr_en, reg_rd_en, reg_hit, vout_enable, ov_warn, uv_warn, uv_fault;
  logic        fault_off, retry_active;
  logic [2:0]  attempt_count;
  logic [7:0]  reg_code;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [15:0] regs [int];
  int          n_fail = 0;
  int          check_count = 0;
  int          r, u, span, last, gap;
  always #10 clk_sys = ~clk_sys;
  pmf_host_model u_host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_code(reg_code), .reg_wdata(reg_wdata));
  pmf_fault_supervisor #(.STEP_CYCLES(STEP)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_code(reg_code), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .ctrl_pin(ctrl_pin), .op_on(op_on),
    .bias_ok(bias_ok), .other_fault_off(other_fault_off), .fault_clear(fault_clear),
    .vout_meas(vout_meas), .vout_enable(vout_enable), .ov_warn(ov_warn), .uv_warn(uv_warn),
    .uv_fault(uv_fault), .fault_off(fault_off), .retry_active(retry_active),
    .attempt_count(attempt_count));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d);
    if (regs.exists(c)) regs[c] = (c == 8'h45) ? {8'h00, d[7:0]} : d;
  endtask
  task automatic rdc(input logic [7:0] c);
    u_host.xfer(1'b0, c, 16'($urandom));
    check("reg_rdata", reg_rdata, regs.exists(c) ? regs[c] : 16'h0000);
    check("reg_hit", reg_hit, regs.exists(c));
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    void'($urandom(32'hA4AC172E));
    regs[8'h42] = `PMF_RST_OV_WARN;
    regs[8'h43] = `PMF_RST_UV_WARN;
    regs[8'h44] = `PMF_RST_UV_FAULT;
    regs[8'h45] = {8'h00, `PMF_RST_UV_RESPONSE};
    regs[8'hD2] = `PMF_RST_TIME_UNIT;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    foreach (regs[c]) rdc(c[7:0]);
    wr(8'h46, 16'h1234);
    rdc(8'h46);
    foreach (regs[c]) wr(c[7:0], 16'($urandom));
    foreach (regs[c]) rdc(c[7:0]);
    wr(8'h42, 16'hF000);
    wr(8'h43, 16'h1800);
    wr(8'h44, 16'h1000);
    wr(8'h45, 16'h0080);
    for (int i = 0; i < 24; i++)
    begin
      v = (i < 3) ? regs[8'h42 + i] : 16'($urandom);
      vout_meas = v;
      cyc(2);
      check("ov_warn", ov_warn, v > regs[8'h42]);
      check("uv_warn", uv_warn, v < regs[8'h43]);
      check("uv_fault", uv_fault, v < regs[8'h44]);
    end
    vout_meas = V_OK;
    op_on = 1'b1;
    cyc(5);
    for (int i = 0; i < 4; i++)
    begin
      {ctrl_pin, op_on, bias_ok, other_fault_off} = OFFS[i];
      cyc(4);
      check("vout_enable", vout_enable, 1'b0);
      {ctrl_pin, op_on, bias_ok, other_fault_off} = 4'hE;
      cyc(6);
      check("vout_enable", vout_enable, 1'b1);
    end
    for (int d = 0; d < 8; d++)
    begin
      r = (d == 7) ? 7 : d;
      u = 1 + $urandom % 2;
      span = UNITS[d] * u * STEP;
      wr(8'hD2, 16'(u));
      wr(8'h45, {8'h00, 2'b10, 3'(r), 3'(d)});
      vout_meas = V_LOW;
      last = 0;
      gap = 0;
      for (int i = 0; i < 6000 && fault_off !== 1'b1 && last < 7; i++)
      begin
        cyc(1);
        gap++;
        if (attempt_count > last)
        begin
          if (last > 0) check("gap", 16'(gap), 16'(span));
          last = attempt_count;
          gap = 0;
        end
      end
      if (r < 7)
      begin
        check("attempts", 16'(last), 16'(r));
        check("fault_off", fault_off, 1'b1);
        vout_meas = V_OK;
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
      end
      else
      begin
        check("fault_off", fault_off, 1'b0);
        op_on = 1'b0;
        cyc(2);
        check("retry_active", retry_active, 1'b0);
        vout_meas = V_OK;
        op_on = 1'b1;
      end
      cyc(4);
      check("vout_enable", vout_enable, 1'b1);
    end
    wr(8'hD2, 16'h0001);
    wr(8'h45, 16'h0098);
    vout_meas = V_LOW;
    for (int i = 0; i < 200 && attempt_count === 3'h0; i++) cyc(1);
    check("attempt_count", attempt_count, 3'h1);
    vout_meas = V_OK;
    cyc(12);
    check("retry_active", retry_active, 1'b0);
    check("vout_enable", vout_enable, 1'b1);
    wr(8'h45, 16'h00C0);
    vout_meas = V_LOW;
    cyc(3);
    check("vout_enable", vout_enable, 1'b0);
    vout_meas = V_OK;
    cyc(3);
    check("vout_enable", vout_enable, 1'b1);
    wr(8'h45, 16'h0000);
    vout_meas = V_LOW;
    cyc(20);
    check("retry_active", retry_active, 1'b0);
    check("vout_enable", vout_enable, 1'b1);
    vout_meas = V_OK;
    wr(8'h45, 16'h004B);
    vout_meas = V_LOW;
    cyc(40);
    check("vout_enable", vout_enable, 1'b0);
    check("retry_active", retry_active, 1'b1);
    vout_meas = V_OK;
    cyc(64);
    check("retry_active", retry_active, 1'b0);
    check("vout_enable", vout_enable, 1'b1);
    wr(8'h45, 16'h0043);
    vout_meas = V_LOW;
    cyc(16);
    check("vout_enable", vout_enable, 1'b1);
    cyc(24);
    check("fault_off", fault_off, 1'b1);
    end_sim();
  end
endmodule

// ==== test/pmf_fault_supervisor_sva.sv ====
// Checker: port timing of the output-voltage fault supervisor.
// Assumes it is bound into pmf_fault_supervisor with its STEP_CYCLES.
`timescale 1ns/100ps
`include "pmf_defs.svh"
module pmf_fault_supervisor_sva
#(
  parameter int STEP_CYCLES = `PMF_UNIT_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Command port
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_code,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_hit,
  // Run inputs and measurement
  input wire logic        ctrl_pin,
  input wire logic        op_on,
  input wire logic        bias_ok,
  input wire logic        other_fault_off,
  input wire logic [15:0] vout_meas,
  // Outputs
  input wire logic        vout_enable,
  input wire logic        ov_warn,
  input wire logic        uv_fault,
  input wire logic        fault_off,
  input wire logic        retry_active,
  input wire logic [2:0]  attempt_count
);
  // ----------------
  // Shadow registers and attempt spacing
  // ----------------
  localparam int DLY_TAB [8] = '{1, 2, 4, 16, 1, 32, 64, 128};
  logic [15:0] ov_reg;
  logic [15:0] uvf_reg;
  logic [15:0] unit_reg;
  logic [7:0]  resp_reg;
  logic [2:0]  prev_att_reg;
  int          gap_reg;
  wire logic        known = (reg_code == 8'h42) || (reg_code == 8'h43) || (reg_code == 8'h44)
                         || (reg_code == 8'h45) || (reg_code == 8'hD2);
  wire logic [31:0] span = DLY_TAB[resp_reg[2:0]] * STEP_CYCLES
                         * ((unit_reg == 16'h0000) ? 1 : int'(unit_reg));
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ov_reg   <= `PMF_RST_OV_WARN;
      uvf_reg  <= `PMF_RST_UV_FAULT;
      unit_reg <= `PMF_RST_TIME_UNIT;
      resp_reg <= `PMF_RST_UV_RESPONSE;
    end
    else if (reg_wr_en)
    begin
      if (reg_code == 8'h42) ov_reg <= reg_wdata;
      if (reg_code == 8'h44) uvf_reg <= reg_wdata;
      if (reg_code == 8'hD2) unit_reg <= reg_wdata;
      if (reg_code == 8'h45) resp_reg <= reg_wdata[7:0];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    prev_att_reg <= attempt_count;
    gap_reg      <= (attempt_count > prev_att_reg) ? 1 : gap_reg + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  run_low_off_a:
  assert property ((!op_on || !bias_ok || other_fault_off || !$past(ctrl_pin, 2))
    |=> !vout_enable) else $error("output enabled while run is low");
  ov_warn_a:
  assert property (ov_warn == ($past(vout_meas) > $past(ov_reg)))
    else $error("over-voltage warning wrong");
  uv_fault_a:
  assert property ((vout_meas < uvf_reg) |=> uv_fault) else $error("fault flag missed");
  read_miss_a:
  assert property ((reg_rd_en && !known) |=> (reg_rdata == 16'h0000) && !reg_hit)
    else $error("unknown code read not empty");
  rdata_hold_a:
  assert property (!reg_rd_en |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("read data moved without read");
  while_off_a:
  assert property ((resp_reg[7:6] == 2'b11 && uv_fault) |=> !vout_enable)
    else $error("output on during fault in mode 11");
  latch_off_a:
  assert property (fault_off |-> !vout_enable && !retry_active)
    else $error("output or retry active while latched off");
  retry_cap_a:
  assert property ((retry_active && resp_reg[5:3] != `PMF_RETRY_CONT)
    |-> attempt_count <= resp_reg[5:3]) else $error("too many restart attempts");
  attempt_spacing_a:
  assert property ((attempt_count > prev_att_reg && prev_att_reg != 3'h0)
    |-> gap_reg == span) else $error("attempt spacing wrong");
endmodule
bind pmf_fault_supervisor pmf_fault_supervisor_sva #(.STEP_CYCLES(STEP_CYCLES)) u_sva
(
  .clk_sys(clk_sys), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_code(reg_code), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .ctrl_pin(ctrl_pin), .op_on(op_on), .bias_ok(bias_ok), .other_fault_off(other_fault_off),
  .vout_meas(vout_meas), .vout_enable(vout_enable), .ov_warn(ov_warn), .uv_fault(uv_fault),
  .fault_off(fault_off), .retry_active(retry_active), .attempt_count(attempt_count)
);

// ==== test/pmf_host_model.sv ====
// Host model: drives decoded command writes and reads of the supervisor.
// Assumes strobes are taken on the rising edge of clk_sys.
`timescale 1ns/100ps
module pmf_host_model
(
  // Clock
  input  wire logic   clk_sys,
  // Command port
  output logic        reg_wr_en,
  output logic        reg_rd_en,
  output logic [7:0]  reg_code,
  output logic [15:0] reg_wdata
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_code  = 8'h00;
    reg_wdata = 16'h0000;
  end
  // ----------------
  // One access, then released lines show inverted data
  // ----------------
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr_en = wr;
    reg_rd_en = !wr;
    reg_code  = c;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_code  = ~c;
    reg_wdata = ~d;
  endtask
endmodule
